// *** rtl/metering_pkg.sv ***
// Constants shared by the metering datapath: register indices, field
// positions, reset values, filter shifts and the sequencer states.
// Assumes a 32-bit APB master reaching index * 4 as the byte address.
package metering_pkg;
    // ========================================================
    // Widths
    localparam int ADDR_W = 16;
    localparam int SAMPLE_W = 16;
    // ========================================================
    // Register indices (byte address = index * 4)
    localparam logic [13:0] IDX_INST_PRI = 14'h10D1;
    localparam logic [13:0] IDX_INST_SEC = 14'h10D2;
    localparam logic [13:0] IDX_AVG_PRI = 14'h10D6;
    localparam logic [13:0] IDX_AVG_SEC = 14'h10D7;
    localparam logic [13:0] IDX_APPARENT = 14'h10DA;
    localparam logic [13:0] IDX_GAIN_PRI = 14'h10E8;
    localparam logic [13:0] IDX_GAIN_SEC = 14'h10E9;
    localparam logic [13:0] IDX_OFS_PRI = 14'h10ED;
    localparam logic [13:0] IDX_OFS_SEC = 14'h10EE;
    localparam logic [13:0] IDX_CTRL_A = 14'h2878;
    localparam logic [13:0] IDX_CTRL_C = 14'h287A;
    localparam logic [13:0] IDX_CTRL_D = 14'h287D;
    localparam logic [13:0] IDX_DETECT = 14'h2886;
    // ========================================================
    // Field positions
    localparam int CTRL_A_ENABLE_BIT = 4;
    localparam int CTRL_C_SEL_BIT = 4;
    localparam int CTRL_D_ENERGY_BIT = 3;
    localparam int DETECT_GATE_BIT = 7;
    // ========================================================
    // Reset values
    localparam logic [31:0] RESULT_RESET = 32'h0000_0000;
    localparam logic [31:0] CAL_RESET = 32'h0000_0000;
    localparam logic [7:0] CTRL_RESET = 8'h00;
    // ========================================================
    // Filter, averaging and gain constants
    localparam int HPF_SHIFT = 8;
    localparam int INTEG_LEAK_SHIFT = 6;
    localparam int LPF_SHIFT = 4;
    localparam int AVG_LOG2 = 6;
    localparam int GAIN_FRAC = 31;
    // ========================================================
    // Sequencer states
    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_FILT = 2'b01,
        ST_PROD = 2'b10,
        ST_CAL = 2'b11
    } seq_state_t;
endpackage

// *** rtl/power_metering_datapath.sv ***
// Power metering datapath: apparent, active and reactive power with gain
// and offset calibration, block averaging and an APB register file.
// Assumes ADC samples and averaged RMS values on the same clock, and one
// reset that combines power-on, brown-out, pin and watchdog causes.
//
// Added by the designer: the APB interface to the registers.
`timescale 1ns/1ns
// Operation
// R1 - Apparent power is current RMS times voltage RMS
// R2 - Apparent power runs only with RMS enable
// R3 - Apparent result 32-bit signed, cleared by reset
// R4 - Active/reactive share the RMS enable
// R5 - Primary path: active power, first current only
// R6 - Select bit: reactive first or active second
// R7 - Reactive mode inverts sign for accumulator routing
// R8 - Active: high-pass, multiply, low-pass filter
// R9 - Gain then offset; instantaneous results stored
// R10 - Averages stored per path
// R11 - Result registers 32-bit signed, reset cleared
// R12 - Gain word range down to +49.9 percent
// R13 - Offset word range plus/minus half scale
// R14 - Calibration words 32-bit signed, reset cleared
// R15 - Reactive current integrated for 90 degree shift
// R16 - Reactive: multiply, filter, calibrate, store, average
// R17 - Reactive uses secondary gain and offset words
// R18 - Energy enable bit, off after reset
// R19 - Compute enable bit, default disabled
// R20 - Gate stops computing, energy keeps running
// R21 - Gain multiplies by one plus word, saturating
// R22 - Fixed block average, updated per block
module power_metering_datapath (
    input wire logic I_REF_CLK,
    input wire logic I_RST_N,
    input wire logic I_PSEL,
    input wire logic I_PENABLE,
    input wire logic I_PWRITE,
    input wire logic [15:0] I_PADDR,
    input wire logic [31:0] I_PWDATA,
    output logic [31:0] O_PRDATA,
    output logic O_PREADY,
    output logic O_PSLVERR,
    input wire logic I_SAMPLE_VALID,
    input wire logic signed [15:0] I_CUR1,
    input wire logic signed [15:0] I_CUR2,
    input wire logic signed [15:0] I_VOLT,
    input wire logic I_RMS_VALID,
    input wire logic signed [31:0] I_IRMS_AVG,
    input wire logic signed [31:0] I_URMS_AVG,
    output logic O_COMPUTE_RUN,
    output logic O_ENERGY_ENABLE,
    output logic O_POWER_STROBE,
    output logic [31:0] O_PRI_POWER,
    output logic [31:0] O_SEC_POWER,
    output logic O_SEC_TO_POS
);
    // ========================================================
    // Declarations
    logic [31:0] gain_reg [2];
    logic [31:0] ofs_reg [2];
    logic [31:0] inst_reg [2];
    logic [31:0] avg_reg [2];
    logic [31:0] apparent_reg;
    logic [7:0] ctrl_a_reg;
    logic [7:0] ctrl_c_reg;
    logic [7:0] ctrl_d_reg;
    logic [7:0] detect_reg;
    logic [31:0] prdata_reg;
    logic strobe_reg;
    metering_pkg::seq_state_t state_reg;
    metering_pkg::seq_state_t state_next;
    logic run;
    logic sel_active2;
    logic start;
    logic [13:0] idx;
    logic wr_en;
    logic mapped;
    logic [31:0] rd_mux;
    logic signed [15:0] chan_in [3];
    logic signed [15:0] hpf_reg [3];
    logic signed [23:0] dc_reg [3];
    logic signed [23:0] integ_reg;
    logic signed [15:0] integ_out;
    logic signed [15:0] sec_cur;
    logic signed [31:0] sec_prod;
    logic signed [31:0] prod [2];
    logic signed [31:0] lpf_reg [2];
    logic signed [31:0] cal_sat [2];
    logic signed [37:0] acc_reg [2];
    logic [metering_pkg::AVG_LOG2-1:0] avg_cnt_reg;
    logic signed [63:0] app_prod;

    // ========================================================
    // Enables
    // Gate stops sampling and computing, not the energy enable
    assign run = ctrl_a_reg[metering_pkg::CTRL_A_ENABLE_BIT]
        & ~detect_reg[metering_pkg::DETECT_GATE_BIT]; // [R19] [R20] [R4]
    assign sel_active2 = ctrl_c_reg[metering_pkg::CTRL_C_SEL_BIT];
    assign start = I_SAMPLE_VALID & run;
    assign O_COMPUTE_RUN = run; // [R2]
    assign O_ENERGY_ENABLE =
        ctrl_d_reg[metering_pkg::CTRL_D_ENERGY_BIT]; // [R18] [R20]

    // ========================================================
    // APB decode
    assign idx = I_PADDR[15:2];
    assign wr_en = I_PSEL & I_PENABLE & I_PWRITE;
    assign O_PREADY = 1'b1;
    assign O_PSLVERR = I_PSEL & I_PENABLE & ~mapped;
    assign O_PRDATA = prdata_reg;

    // Read mux; narrow registers sit in the low bits, unmapped reads zero
    always_comb begin
        mapped = 1'b1;
        rd_mux = 32'h0000_0000;
        unique case (idx)
            metering_pkg::IDX_INST_PRI: rd_mux = inst_reg[0];
            metering_pkg::IDX_INST_SEC: rd_mux = inst_reg[1];
            metering_pkg::IDX_AVG_PRI: rd_mux = avg_reg[0];
            metering_pkg::IDX_AVG_SEC: rd_mux = avg_reg[1];
            metering_pkg::IDX_APPARENT: rd_mux = apparent_reg;
            metering_pkg::IDX_GAIN_PRI: rd_mux = gain_reg[0];
            metering_pkg::IDX_GAIN_SEC: rd_mux = gain_reg[1];
            metering_pkg::IDX_OFS_PRI: rd_mux = ofs_reg[0];
            metering_pkg::IDX_OFS_SEC: rd_mux = ofs_reg[1];
            metering_pkg::IDX_CTRL_A: rd_mux = {24'h000000, ctrl_a_reg};
            metering_pkg::IDX_CTRL_C: rd_mux = {24'h000000, ctrl_c_reg};
            metering_pkg::IDX_CTRL_D: rd_mux = {24'h000000, ctrl_d_reg};
            metering_pkg::IDX_DETECT: rd_mux = {24'h000000, detect_reg};
            default: mapped = 1'b0;
        endcase
    end

    // Read data captured in the setup cycle so it leaves a flip-flop
    always_ff @(posedge I_REF_CLK) begin
        if (!I_RST_N) begin
            prdata_reg <= 32'h0000_0000;
        end else if (I_PSEL && !I_PENABLE && !I_PWRITE) begin
            prdata_reg <= rd_mux;
        end
    end

    // Control bytes; all default to zero so compute and energy are off
    always_ff @(posedge I_REF_CLK) begin
        if (!I_RST_N) begin
            ctrl_a_reg <= metering_pkg::CTRL_RESET; // [R19]
            ctrl_c_reg <= metering_pkg::CTRL_RESET; // [R6]
            ctrl_d_reg <= metering_pkg::CTRL_RESET; // [R18]
            detect_reg <= metering_pkg::CTRL_RESET;
        end else if (wr_en) begin
            if (idx == metering_pkg::IDX_CTRL_A) begin
                ctrl_a_reg <= I_PWDATA[7:0];
            end
            if (idx == metering_pkg::IDX_CTRL_C) begin
                ctrl_c_reg <= I_PWDATA[7:0];
            end
            if (idx == metering_pkg::IDX_CTRL_D) begin
                ctrl_d_reg <= I_PWDATA[7:0];
            end
            if (idx == metering_pkg::IDX_DETECT) begin
                detect_reg <= I_PWDATA[7:0];
            end
        end
    end

    // Calibration words; range limits are left to software
    always_ff @(posedge I_REF_CLK) begin
        if (!I_RST_N) begin
            gain_reg[0] <= metering_pkg::CAL_RESET; // [R14]
            gain_reg[1] <= metering_pkg::CAL_RESET;
            ofs_reg[0] <= metering_pkg::CAL_RESET;
            ofs_reg[1] <= metering_pkg::CAL_RESET;
        end else if (wr_en) begin
            if (idx == metering_pkg::IDX_GAIN_PRI) begin
                gain_reg[0] <= I_PWDATA; // [R12]
            end
            if (idx == metering_pkg::IDX_GAIN_SEC) begin
                gain_reg[1] <= I_PWDATA; // [R12] [R17]
            end
            if (idx == metering_pkg::IDX_OFS_PRI) begin
                ofs_reg[0] <= I_PWDATA; // [R13]
            end
            if (idx == metering_pkg::IDX_OFS_SEC) begin
                ofs_reg[1] <= I_PWDATA; // [R13] [R17]
            end
        end
    end

    // ========================================================
    // Sequencer: one sample walks filter, product, calibration
    // Samples arriving while busy are dropped; keep 4 cycles apart
    always_comb begin
        state_next = state_reg;
        unique case (state_reg)
            metering_pkg::ST_IDLE: state_next = start ? metering_pkg::ST_FILT
                : metering_pkg::ST_IDLE;
            metering_pkg::ST_FILT: state_next = metering_pkg::ST_PROD;
            metering_pkg::ST_PROD: state_next = metering_pkg::ST_CAL;
            metering_pkg::ST_CAL: state_next = metering_pkg::ST_IDLE;
        endcase
        if (!run) begin
            state_next = metering_pkg::ST_IDLE; // [R4]
        end
    end

    always_ff @(posedge I_REF_CLK) begin
        if (!I_RST_N) begin
            state_reg <= metering_pkg::ST_IDLE;
        end else begin
            state_reg <= state_next;
        end
    end

    // ========================================================
    // High-pass filters on first current, second current, voltage
    assign chan_in[0] = I_CUR1;
    assign chan_in[1] = I_CUR2;
    assign chan_in[2] = I_VOLT;

    for (genvar c = 0; c < 3; c++) begin : g_hpf
        logic signed [23:0] diff;
        // DC tracker subtracted from the sample; 8-bit fraction kept
        assign diff = $signed({chan_in[c], 8'h00}) - dc_reg[c];
        always_ff @(posedge I_REF_CLK) begin
            if (!I_RST_N) begin
                dc_reg[c] <= 24'sh000000;
                hpf_reg[c] <= 16'sh0000;
            end else if (state_reg == metering_pkg::ST_IDLE && start) begin
                dc_reg[c] <= dc_reg[c] + (diff >>> metering_pkg::HPF_SHIFT);
                hpf_reg[c] <= diff[23:8]; // [R8]
            end
        end
    end

    // ========================================================
    // Leaky integrator for the 90 degree shift of the first current
    // Its extra gain is not trimmed here; the secondary gain word does it
    always_ff @(posedge I_REF_CLK) begin
        if (!I_RST_N) begin
            integ_reg <= 24'sh000000;
        end else if (state_reg == metering_pkg::ST_FILT) begin
            integ_reg <= integ_reg
                - (integ_reg >>> metering_pkg::INTEG_LEAK_SHIFT)
                + 24'(hpf_reg[0]); // [R15]
        end
    end

    assign integ_out = integ_reg[21:6];
    assign sec_cur = sel_active2 ? hpf_reg[1] : integ_out; // [R6]

    // Primary path is always first current times voltage
    assign prod[0] = 32'(hpf_reg[0]) * 32'(hpf_reg[2]); // [R5] [R8]
    // Full-width product first; a cast around it would keep 16 bits
    assign sec_prod = 32'(sec_cur) * 32'(hpf_reg[2]);
    // Reactive mode inverts sign so positive current lands negative
    assign prod[1] = sel_active2 ? sec_prod : -sec_prod; // [R7] [R16]

    // ========================================================
    // Per path: low-pass, calibration, instantaneous and average
    for (genvar p = 0; p < 2; p++) begin : g_path
        logic signed [32:0] lpf_diff;
        logic signed [63:0] gmul;
        logic signed [33:0] cal_sum;
        assign lpf_diff = 33'(prod[p]) - 33'(lpf_reg[p]);
        assign gmul = 64'(lpf_reg[p]) * 64'($signed(gain_reg[p]));
        // Raw * (1 + gain) + offset, then clamp to 32-bit signed
        assign cal_sum = 34'(lpf_reg[p])
            + 34'(gmul >>> metering_pkg::GAIN_FRAC)
            + 34'($signed(ofs_reg[p])); // [R21] [R9] [R17]
        assign cal_sat[p] = (cal_sum > 34'sh0_7FFF_FFFF) ? 32'sh7FFF_FFFF
            : (cal_sum < -34'sh0_8000_0000) ? 32'sh8000_0000
            : cal_sum[31:0]; // [R21]

        // Low-pass filter removes the ripple of the product
        always_ff @(posedge I_REF_CLK) begin
            if (!I_RST_N) begin
                lpf_reg[p] <= 32'sh0000_0000;
            end else if (state_reg == metering_pkg::ST_PROD) begin
                lpf_reg[p] <= lpf_reg[p]
                    + 32'(lpf_diff >>> metering_pkg::LPF_SHIFT); // [R8]
            end
        end

        // Instantaneous result
        always_ff @(posedge I_REF_CLK) begin
            if (!I_RST_N) begin
                inst_reg[p] <= metering_pkg::RESULT_RESET; // [R11]
            end else if (state_reg == metering_pkg::ST_CAL) begin
                inst_reg[p] <= cal_sat[p]; // [R9] [R16]
            end
        end

        // Block average; the register moves only at block end
        always_ff @(posedge I_REF_CLK) begin
            if (!I_RST_N) begin
                acc_reg[p] <= 38'sh0;
                avg_reg[p] <= metering_pkg::RESULT_RESET; // [R11]
            end else if (state_reg == metering_pkg::ST_CAL) begin
                if (&avg_cnt_reg) begin
                    acc_reg[p] <= 38'sh0;
                    avg_reg[p] <= 32'((acc_reg[p] + 38'(cal_sat[p]))
                        >>> metering_pkg::AVG_LOG2); // [R10] [R22]
                end else begin
                    acc_reg[p] <= acc_reg[p] + 38'(cal_sat[p]); // [R22]
                end
            end
        end
    end

    // Block sample counter shared by both paths
    always_ff @(posedge I_REF_CLK) begin
        if (!I_RST_N) begin
            avg_cnt_reg <= '0;
        end else if (state_reg == metering_pkg::ST_CAL) begin
            avg_cnt_reg <= avg_cnt_reg + 1'b1; // [R22]
        end
    end

    // ========================================================
    // Apparent power from the averaged RMS pair
    assign app_prod = 64'(I_IRMS_AVG) * 64'(I_URMS_AVG);

    always_ff @(posedge I_REF_CLK) begin
        if (!I_RST_N) begin
            apparent_reg <= metering_pkg::RESULT_RESET; // [R3]
        end else if (I_RMS_VALID && run) begin
            apparent_reg <= app_prod[62:31]; // [R1] [R2]
        end
    end

    // ========================================================
    // Hand-off to the energy accumulators, registered from a calibration cycle with energy on
    always_ff @(posedge I_REF_CLK) begin
        if (!I_RST_N) begin
            strobe_reg <= 1'b0;
        end else begin
            strobe_reg <= (state_reg == metering_pkg::ST_CAL)
                & O_ENERGY_ENABLE; // [R18]
        end
    end

    assign O_POWER_STROBE = strobe_reg;
    assign O_PRI_POWER = inst_reg[0];
    assign O_SEC_POWER = inst_reg[1];
    // Sign already inverted in reactive mode, so this routes directly
    assign O_SEC_TO_POS = ~inst_reg[1][31]; // [R7]
endmodule

// *** sim/power_metering_datapath_props.sv ***
// Checker for the metering datapath: APB answers, sample timing and
// control outputs. Sees only the top ports; bound after the module.
`timescale 1ns/1ns
module power_metering_datapath_props (
    input wire logic I_REF_CLK,
    input wire logic I_RST_N,
    input wire logic I_PSEL,
    input wire logic I_PENABLE,
    input wire logic I_PWRITE,
    input wire logic [15:0] I_PADDR,
    input wire logic [31:0] I_PWDATA,
    input wire logic I_SAMPLE_VALID,
    input wire logic [31:0] O_PRDATA,
    input wire logic O_PSLVERR,
    input wire logic O_COMPUTE_RUN,
    input wire logic O_ENERGY_ENABLE,
    input wire logic O_POWER_STROBE,
    input wire logic [31:0] O_PRI_POWER,
    input wire logic [31:0] O_SEC_POWER,
    input wire logic O_SEC_TO_POS
);
    // ==========================================================
    // Helpers
    logic acc, take, wd_energy, wd_run, wd_gate;
    logic [13:0] idx;
    assign idx = I_PADDR[15:2];
    assign acc = I_PSEL & I_PENABLE;
    // Over-inclusive take: only ever used as a required cause
    assign take = I_SAMPLE_VALID & O_COMPUTE_RUN;
    assign wd_energy = I_PWDATA[metering_pkg::CTRL_D_ENERGY_BIT];
    assign wd_run = I_PWDATA[metering_pkg::CTRL_A_ENABLE_BIT];
    assign wd_gate = I_PWDATA[metering_pkg::DETECT_GATE_BIT];
    default clocking cb @(posedge I_REF_CLK); endclocking
    default disable iff (!I_RST_N);
    // ==========================================================
    // Sequences
    sequence s_wr(logic [13:0] a);
        acc && I_PWRITE && idx == a;
    endsequence
    sequence s_energy_off;
        !O_ENERGY_ENABLE [*5];
    endsequence
    // ==========================================================
    // Assertions
    AST_LOW_INDEX_ERR: assert property (acc && idx < 14'h10D1 |->
        O_PSLVERR && (I_PWRITE || O_PRDATA == 32'h0))
        else $error("unmapped access not refused");
    AST_IDLE_NO_ERR: assert property (!acc |-> !O_PSLVERR)
        else $error("error flag outside access phase");
    AST_ENERGY_WRITE: assert property (
        s_wr(metering_pkg::IDX_CTRL_D) |=> O_ENERGY_ENABLE == $past(wd_energy))
        else $error("energy enable does not follow write");
    AST_RUN_OFF_WRITE: assert property (
        s_wr(metering_pkg::IDX_CTRL_A) ##0 !wd_run |=> !O_COMPUTE_RUN)
        else $error("compute still running after disable");
    AST_GATE_WRITE: assert property (
        s_wr(metering_pkg::IDX_DETECT) ##0 wd_gate |=> !O_COMPUTE_RUN)
        else $error("gate did not stop computing");
    AST_STROBE_CAUSE: assert property (O_POWER_STROBE |->
        $past(take, 4) && $past(O_ENERGY_ENABLE))
        else $error("strobe without taken sample or energy");
    AST_STROBE_PULSE: assert property (O_POWER_STROBE |=>
        !O_POWER_STROBE [*3])
        else $error("strobe longer than one cycle");
    AST_NO_STROBE_OFF: assert property (
        s_energy_off |-> !O_POWER_STROBE)
        else $error("strobe while energy disabled");
    AST_PRI_UPDATE: assert property (
        !$stable(O_PRI_POWER) |-> $past(take, 4))
        else $error("primary power changed without sample");
    AST_SEC_UPDATE: assert property (
        !$stable(O_SEC_POWER) |-> $past(take, 4))
        else $error("secondary power changed without sample");
    AST_SEC_ROUTE: assert property (
        O_SEC_TO_POS == !O_SEC_POWER[31])
        else $error("secondary routing disagrees with sign");
endmodule
bind power_metering_datapath power_metering_datapath_props chk (
    .I_REF_CLK(I_REF_CLK), .I_RST_N(I_RST_N), .I_PSEL(I_PSEL),
    .I_PENABLE(I_PENABLE), .I_PWRITE(I_PWRITE), .I_PADDR(I_PADDR),
    .I_PWDATA(I_PWDATA), .I_SAMPLE_VALID(I_SAMPLE_VALID),
    .O_PRDATA(O_PRDATA), .O_PSLVERR(O_PSLVERR),
    .O_COMPUTE_RUN(O_COMPUTE_RUN), .O_ENERGY_ENABLE(O_ENERGY_ENABLE),
    .O_POWER_STROBE(O_POWER_STROBE), .O_PRI_POWER(O_PRI_POWER),
    .O_SEC_POWER(O_SEC_POWER), .O_SEC_TO_POS(O_SEC_TO_POS));

// *** sim/adc_sample_model.sv ***
// Behavioural ADC channel model: a sample every fourth cycle carrying a
// square wave, and an RMS pair every sixteenth cycle.
// Assumes it shares the bench clock and reset.
`timescale 1ns/1ns
module adc_sample_model (
    input wire logic i_clk,
    input wire logic i_rst_n,
    input wire logic i_run,
    input wire logic signed [15:0] i_amp,
    input wire logic signed [31:0] i_irms,
    input wire logic signed [31:0] i_urms,
    output logic o_valid,
    output logic signed [15:0] o_cur1,
    output logic signed [15:0] o_cur2,
    output logic signed [15:0] o_volt,
    output logic o_rms_valid,
    output logic signed [31:0] o_irms,
    output logic signed [31:0] o_urms
);
    logic [3:0] cnt_reg;
    logic signed [15:0] smp;
    // ==========================================================
    // Slot counter; four-cycle spacing keeps the sequencer free
    always_ff @(posedge i_clk) begin
        if (!i_rst_n) begin
            cnt_reg <= 4'h0;
        end else begin
            cnt_reg <= cnt_reg + 4'h1;
        end
    end
    // Lines carry the inverse outside valid cycles, never a held value
    assign smp = cnt_reg[3] ? -i_amp : i_amp;
    assign o_valid = i_run && cnt_reg[1:0] == 2'h3;
    assign o_cur1 = o_valid ? smp : ~smp;
    assign o_cur2 = o_valid ? -smp : smp;
    assign o_volt = o_valid ? smp : ~smp;
    assign o_rms_valid = cnt_reg == 4'hF;
    assign o_irms = o_rms_valid ? i_irms : ~i_irms;
    assign o_urms = o_rms_valid ? i_urms : ~i_urms;
endmodule

// *** sim/tb_power_metering_datapath.sv ***
// Self-checking bench: register access, apparent power, calibration,
// averaging, energy strobes and mid-run reset.
// Assumes the ADC model and the bound checker are compiled alongside.
`timescale 1ns/1ns
module tb_power_metering_datapath;
    logic clk, rst_n, psel, penable, pwrite, pready, pslverr, run;
    logic [15:0] paddr;
    logic [31:0] pwdata, prdata, rd, pri, sec;
    logic err, sv, rv, crun, eng, strobe, to_pos;
    logic signed [15:0] amp, c1, c2, vo;
    logic signed [31:0] irms, urms, ir, ur;
    int num_errors = 0, checked = 0, strobes = 0;
    logic [13:0] regs [13] = '{14'h10D1, 14'h10D2, 14'h10D6, 14'h10D7,
        14'h10DA, 14'h10E8, 14'h10E9, 14'h10ED, 14'h10EE, 14'h2878,
        14'h287A, 14'h287D, 14'h2886};
    adc_sample_model adc (.i_clk(clk), .i_rst_n(rst_n), .i_run(run),
        .i_amp(amp), .i_irms(irms), .i_urms(urms), .o_valid(sv),
        .o_cur1(c1), .o_cur2(c2), .o_volt(vo), .o_rms_valid(rv),
        .o_irms(ir), .o_urms(ur));
    power_metering_datapath dut (.I_REF_CLK(clk), .I_RST_N(rst_n),
        .I_PSEL(psel), .I_PENABLE(penable), .I_PWRITE(pwrite),
        .I_PADDR(paddr), .I_PWDATA(pwdata), .O_PRDATA(prdata),
        .O_PREADY(pready), .O_PSLVERR(pslverr), .I_SAMPLE_VALID(sv),
        .I_CUR1(c1), .I_CUR2(c2), .I_VOLT(vo), .I_RMS_VALID(rv),
        .I_IRMS_AVG(ir), .I_URMS_AVG(ur), .O_COMPUTE_RUN(crun),
        .O_ENERGY_ENABLE(eng), .O_POWER_STROBE(strobe),
        .O_PRI_POWER(pri), .O_SEC_POWER(sec), .O_SEC_TO_POS(to_pos));
    // ==========================================================
    // Clock and strobe counter
    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end
    always @(posedge clk) begin
        if (strobe === 1'b1) strobes++;
    end
    // ==========================================================
    // Tasks
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            num_errors++;
            $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic print_verdict;
        $display("comparisons=%0d mismatches=%0d", checked, num_errors);
        if (num_errors == 0 && checked > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask
    // One APB transfer; request held until pready is seen at an edge
    task automatic xfer(input logic w, input logic [13:0] a,
            input logic [31:0] d);
        int n;
        @(posedge clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= {a, 2'b00};
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        for (n = 0; n < 20; n++) begin
            @(posedge clk);
            if (pready === 1'b1) break;
        end
        if (n == 20) begin
            num_errors++;
            print_verdict();
        end
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic rdc(input logic [13:0] a, input logic [31:0] exp);
        xfer(1'b0, a, 32'h0);
        check(rd, exp);
        check({31'h0, err}, 32'h0);
    endtask
    // ==========================================================
    // Main sequence
    initial begin
        {rst_n, psel, penable, pwrite, run} = 5'h00;
        {paddr, pwdata, amp} = 64'h0;
        irms = 32'h4000_0000;
        urms = 32'h4000_0000;
        repeat (5) @(posedge clk);
        rst_n <= 1'b1;
        foreach (regs[i]) rdc(regs[i], 32'h0);
        check({31'h0, to_pos}, 32'h1);
        $display("test reset values done");
        for (int i = 5; i < 9; i++) begin
            xfer(1'b1, regs[i], 32'h1000_0001 + i);
            rdc(regs[i], 32'h1000_0001 + i);
        end
        xfer(1'b1, 14'h287A, 32'h0000_0010);
        rdc(14'h287A, 32'h0000_0010);
        xfer(1'b1, 14'h10D1, 32'hFFFF_FFFF);
        rdc(14'h10D1, 32'h0);
        xfer(1'b0, 14'h0100, 32'h0);
        check({rd[30:0], err}, 32'h1);
        $display("test register access done");
        repeat (40) @(posedge clk);
        rdc(14'h10DA, 32'h0);
        xfer(1'b1, 14'h2878, 32'h0000_0010);
        repeat (40) @(posedge clk);
        rdc(14'h10DA, 32'h2000_0000);
        check({31'h0, crun}, 32'h1);
        xfer(1'b1, 14'h2886, 32'h0000_0080);
        @(posedge clk);
        check({31'h0, crun}, 32'h0);
        irms <= 32'h2000_0000;
        repeat (40) @(posedge clk);
        rdc(14'h10DA, 32'h2000_0000);
        xfer(1'b1, 14'h2886, 32'h0);
        repeat (40) @(posedge clk);
        rdc(14'h10DA, 32'h1000_0000);
        $display("test apparent power done");
        // Zero samples leave only the offsets in the results
        xfer(1'b1, 14'h10ED, 32'h0000_1234);
        xfer(1'b1, 14'h10EE, 32'hFFFF_F000);
        xfer(1'b1, 14'h287D, 32'h0000_0008);
        run <= 1'b1;
        repeat (30) @(posedge clk);
        rdc(14'h10D1, 32'h0000_1234);
        rdc(14'h10D2, 32'hFFFF_F000);
        check({31'h0, to_pos}, 32'h0);
        rdc(14'h10D6, 32'h0);
        repeat (300) @(posedge clk);
        rdc(14'h10D6, 32'h0000_1234);
        rdc(14'h10D7, 32'hFFFF_F000);
        check({31'h0, eng}, 32'h1);
        check({31'h0, strobes != 0}, 32'h1);
        xfer(1'b1, 14'h287D, 32'h0);
        // A strobe already launched at the disabling edge is let through
        repeat (2) @(posedge clk);
        strobes = 0;
        repeat (40) @(posedge clk);
        check(strobes, 32'h0);
        $display("test calibration and averaging done");
        amp <= 16'sh2000;
        // Second current is the inverted wave, so its power is negative
        repeat (300) @(posedge clk);
        check({31'h0, pri[31]}, 32'h0);
        check({31'h0, sec[31]}, 32'h1);
        xfer(1'b1, 14'h287A, 32'h0);
        repeat (300) @(posedge clk);
        check({31'h0, pri[31]}, 32'h0);
        check({31'h0, sec[31]}, 32'h1);
        check({31'h0, to_pos}, 32'h0);
        $display("test active and reactive sign done");
        rst_n <= 1'b0;
        repeat (2) @(posedge clk);
        rst_n <= 1'b1;
        run <= 1'b0;
        rdc(14'h10D2, 32'h0);
        rdc(14'h10EE, 32'h0);
        rdc(14'h2878, 32'h0);
        check({31'h0, eng}, 32'h0);
        $display("test mid-run reset done");
        print_verdict();
    end
endmodule
